/* rtl/irq_logic_pkg.sv */
package irq_logic_pkg;
    // ==========================================================
    // register addresses
    localparam logic [5:0] ADDR_CTRL_ONE = 6'h04;
    localparam logic [5:0] ADDR_ENABLE = 6'h0e;
    localparam logic [5:0] ADDR_PENDING = 6'h0f;
    localparam logic [5:0] ADDR_IDENT = 6'h1e;
    // ==========================================================
    // event bit positions in pending and enable registers
    localparam int EV_SYNTH_LOCK = 0;
    localparam int EV_SYNTH_UNLOCK = 1;
    localparam int EV_FRAME_START = 2;
    localparam int EV_FRAME_DONE = 3;
    localparam int EV_WAKE_MEASURE = 4;
    localparam int EV_ADDR_MATCH = 5;
    localparam int EV_BUF_VIOLATION = 6;
    localparam int EV_SUPPLY_LOW = 7;
    // ==========================================================
    // control register fields
    localparam int CTL_POLARITY = 0;
    localparam int CTL_POLL_MODE = 1;
    localparam int CTL_STATUS_SEL_LO = 2;
    localparam int CTL_STATUS_SEL_HI = 3;
    localparam int CTL_EMPTY_IND_EN = 4;
    localparam int CTL_AUTO_CHECKSUM = 5;
    localparam int CTL_FRAME_PIN_EN = 6;
    localparam int CTL_FRONT_END_EN = 7;
    localparam logic [1:0] STATUS_SEL_PENDING = 2'h3;
    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] PENDING_RESET = 8'h00;
    // ==========================================================
    // transceiver states seen by this block
    typedef enum logic [2:0] {
        ST_IDLE_CLOCK,
        ST_RECEIVE_LISTEN,
        ST_BUSY_RECEIVE,
        ST_BUSY_TRANSMIT,
        ST_RETRYING_TRANSMIT,
        ST_OTHER
    } trx_state_e;
endpackage : irq_logic_pkg

/* rtl/event_capture.sv */
`timescale 1ns/1ps
// ==============================================================
// sticky pending-event register with read-clear
module event_capture #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set_pulse,
    input wire logic [WIDTH-1:0] kill_pulse,
    input wire logic read_clear,
    output logic [WIDTH-1:0] pending_q
);
    // per bit: set wins over read clear and over cross-kill
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    pending_q[i] <= 1'b0;
                end else if (set_pulse[i]) begin
                    pending_q[i] <= 1'b1;
                end else if (read_clear || kill_pulse[i]) begin
                    pending_q[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule : event_capture

/* rtl/radio_interrupt_logic.sv */
`timescale 1ns/1ps
// Contract
// - enable register bit 1 lets its event drive the interrupt line
// - each pending event latches into its own status bit
// - enabled pending events are ORed onto one interrupt line
// - reading status returns contents, then clears bits and line, except bits set in the read cycle, which stay
// - pending bits are sticky until status read, reset, or the opposite lock/unlock event
// - lock event clears unlock bit, unlock event clears lock bit
// - bits 7..0: supply, violation, match, wake/measure, end, start, unlock, lock
// - bit 4 means wakeup in idle entry, measurement done in receive
// - unlock during busy or retrying transmit kills power amplifier now
// - frame start fires at payload start; state goes busy receive
// - frame end fires on reception end and on transmission end
// - reset clears the enable register
// - polling mode records masked events without asserting the line
// - control bit 0 picks line polarity, 0 active high
// - buffer empty indicator ignores polarity, always active high
// - enabled empty indicator replaces interrupt on line during buffer read
// - control bit 6 drives aux output two from header to reception end
// - control also holds front end, checksum, empty indicator, status select
// - status select 3 puts pending register in serial status byte
module radio_interrupt_logic #(
    parameter logic [7:0] IDENT_VALUE = 8'h5a // arbitrary identification value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire irq_logic_pkg::trx_state_e trx_state,
    input wire logic ev_supply_low,
    input wire logic ev_buffer_violation,
    input wire logic ev_address_match,
    input wire logic ev_wakeup_done,
    input wire logic ev_channel_measure_done,
    input wire logic ev_frame_start,
    input wire logic ev_frame_rx_done,
    input wire logic ev_frame_tx_done,
    input wire logic ev_synth_unlock,
    input wire logic ev_synth_lock,
    input wire logic frame_buffer_reading,
    input wire logic buffer_empty,
    output logic irq_line,
    output logic aux_output_two,
    output logic pa_off,
    output logic [7:0] serial_status_byte,
    output logic front_end_control_enable,
    output logic tx_auto_checksum
);
    import irq_logic_pkg::*;

    // ==========================================================
    // register storage
    logic [7:0] ctrl_one_q;
    logic [7:0] enable_q;
    logic [7:0] pending_q;
    logic [7:0] event_vec;
    logic [7:0] kill_vec;
    logic read_pending;
    logic irq_request;
    logic frame_active_q;
    logic state_in_receive;

    // address match helper, used by write and read decoding
    function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
        return a == b;
    endfunction : hit

    // control register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_one_q <= CTRL_ONE_RESET;
        end else if (reg_wr && hit(reg_addr, ADDR_CTRL_ONE)) begin
            ctrl_one_q <= reg_wdata;
        end
    end

    // enable register writes, cleared on reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable_q <= ENABLE_RESET;
        end else if (reg_wr && hit(reg_addr, ADDR_ENABLE)) begin
            enable_q <= reg_wdata;
        end
    end

    // ==========================================================
    // event collection
    assign state_in_receive = (trx_state == ST_RECEIVE_LISTEN) || (trx_state == ST_BUSY_RECEIVE);

    // bit 4 meaning follows transceiver state
    always_comb begin
        event_vec = 8'h00;
        event_vec[EV_SUPPLY_LOW] = ev_supply_low;
        event_vec[EV_BUF_VIOLATION] = ev_buffer_violation;
        event_vec[EV_ADDR_MATCH] = ev_address_match;
        event_vec[EV_WAKE_MEASURE] = state_in_receive ? ev_channel_measure_done
                                                      : ev_wakeup_done;
        event_vec[EV_FRAME_DONE] = ev_frame_rx_done || ev_frame_tx_done;
        event_vec[EV_FRAME_START] = ev_frame_start;
        event_vec[EV_SYNTH_UNLOCK] = ev_synth_unlock;
        event_vec[EV_SYNTH_LOCK] = ev_synth_lock;
    end

    // without polling mode only enabled events are recorded
    logic [7:0] record_vec;
    assign record_vec = ctrl_one_q[CTL_POLL_MODE] ? event_vec
                                                 : (event_vec & enable_q);

    // lock and unlock cancel each other
    always_comb begin
        kill_vec = 8'h00;
        kill_vec[EV_SYNTH_LOCK] = ev_synth_unlock;
        kill_vec[EV_SYNTH_UNLOCK] = ev_synth_lock;
    end

    assign read_pending = reg_rd && hit(reg_addr, ADDR_PENDING);

    event_capture #(
        .WIDTH(8)
    ) u_capture (
        .clk_sys(clk_sys),
        .rst(rst),
        .set_pulse(record_vec),
        .kill_pulse(kill_vec),
        .read_clear(read_pending),
        .pending_q(pending_q)
    );

    // ==========================================================
    // register read data, captured before the clear lands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (hit(reg_addr, ADDR_CTRL_ONE)) begin
                reg_rdata <= ctrl_one_q;
            end else if (hit(reg_addr, ADDR_ENABLE)) begin
                reg_rdata <= enable_q;
            end else if (hit(reg_addr, ADDR_PENDING)) begin
                reg_rdata <= pending_q;
            end else if (hit(reg_addr, ADDR_IDENT)) begin
                reg_rdata <= IDENT_VALUE;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // serial status byte follows the select field
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serial_status_byte <= 8'h00;
        end else if (ctrl_one_q[CTL_STATUS_SEL_HI:CTL_STATUS_SEL_LO] == STATUS_SEL_PENDING) begin
            serial_status_byte <= pending_q;
        end else begin
            serial_status_byte <= 8'h00;
        end
    end

    // ==========================================================
    // interrupt line: request with polarity applied, or empty indicator
    assign irq_request = |(pending_q & enable_q);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_line <= 1'b0;
        end else if (ctrl_one_q[CTL_EMPTY_IND_EN] && frame_buffer_reading) begin
            irq_line <= buffer_empty;
        end else begin
            irq_line <= irq_request ^ ctrl_one_q[CTL_POLARITY];
        end
    end

    // ==========================================================
    // frame-start pin active from header until reception end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frame_active_q <= 1'b0;
        end else if (ev_frame_start) begin
            frame_active_q <= 1'b1;
        end else if (ev_frame_rx_done) begin
            frame_active_q <= 1'b0;
        end
    end
    assign aux_output_two = ctrl_one_q[CTL_FRAME_PIN_EN] & frame_active_q;

    // power amplifier off on unlock during a transmission
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pa_off <= 1'b0;
        end else begin
            pa_off <= ev_synth_unlock && ((trx_state == ST_BUSY_TRANSMIT)
                      || (trx_state == ST_RETRYING_TRANSMIT));
        end
    end

    assign front_end_control_enable = ctrl_one_q[CTL_FRONT_END_EN];
    assign tx_auto_checksum = ctrl_one_q[CTL_AUTO_CHECKSUM];

    // ==========================================================
    // checks
    // read with no new event empties the register
    a_read_clears_all: assert property (@(posedge clk_sys) disable iff (rst)
        read_pending && (record_vec == 8'h00) |=> pending_q == 8'h00)
        else $error("status read did not clear pending bits");
    // address match event racing a read is kept
    a_event_kept_pending: assert property (@(posedge clk_sys) disable iff (rst)
        record_vec[EV_ADDR_MATCH] |=> pending_q[EV_ADDR_MATCH])
        else $error("recorded event was lost");
    // supply low bit holds without a read
    a_sticky_bits: assert property (@(posedge clk_sys) disable iff (rst)
        pending_q[EV_SUPPLY_LOW] && !read_pending |=> pending_q[EV_SUPPLY_LOW])
        else $error("pending bit dropped without read");
    // lock clears a pending unlock
    a_lock_kills_unlock: assert property (@(posedge clk_sys) disable iff (rst)
        ev_synth_lock && !ev_synth_unlock |=> !pending_q[EV_SYNTH_UNLOCK])
        else $error("lock did not clear unlock bit");
    // masked events are dropped outside polling
    a_masked_not_recorded: assert property (@(posedge clk_sys) disable iff (rst)
        !ctrl_one_q[CTL_POLL_MODE] && !enable_q[EV_FRAME_START] && read_pending
        |=> !pending_q[EV_FRAME_START])
        else $error("masked event recorded outside polling");
    // line is the or of enabled bits with polarity applied
    a_line_follows_or: assert property (@(posedge clk_sys) disable iff (rst)
        !(ctrl_one_q[CTL_EMPTY_IND_EN] && frame_buffer_reading)
        |=> irq_line == ($past(irq_request) ^ $past(ctrl_one_q[CTL_POLARITY])))
        else $error("interrupt line wrong");
    // reset masks every event
    a_enable_reset: assert property (@(posedge clk_sys)
        rst |=> enable_q == 8'h00)
        else $error("enable register not cleared by reset");
    // unlock while sending stops the amplifier
    a_pa_off_unlock: assert property (@(posedge clk_sys) disable iff (rst)
        ev_synth_unlock && trx_state == ST_BUSY_TRANSMIT |=> pa_off)
        else $error("amplifier not switched off");
    // frame start raises the aux pin
    a_aux_frame: assert property (@(posedge clk_sys) disable iff (rst)
        ev_frame_start && ctrl_one_q[CTL_FRAME_PIN_EN] && !reg_wr
        |=> aux_output_two)
        else $error("aux output two not raised");

    // ==========================================================
    // checks on event mapping and register outputs
    // unlock clears a pending lock bit
    a_unlock_kills_lock: assert property (@(posedge clk_sys) disable iff (rst)
        ev_synth_unlock && !ev_synth_lock |=> !pending_q[EV_SYNTH_LOCK])
        else $error("unlock did not clear lock bit");
    // recorded lock lands on bit 0
    a_lock_recorded: assert property (@(posedge clk_sys) disable iff (rst)
        record_vec[EV_SYNTH_LOCK] |=> pending_q[EV_SYNTH_LOCK])
        else $error("lock event not latched");
    // supply low lands on bit 7
    a_supply_maps_bit7: assert property (@(posedge clk_sys) disable iff (rst)
        ev_supply_low && enable_q[EV_SUPPLY_LOW] |=> pending_q[EV_SUPPLY_LOW])
        else $error("supply low not on bit 7");
    // measurement done sets bit 4 in receive states
    a_measure_in_receive: assert property (@(posedge clk_sys) disable iff (rst)
        ev_channel_measure_done && state_in_receive && enable_q[EV_WAKE_MEASURE]
        |=> pending_q[EV_WAKE_MEASURE])
        else $error("measurement done not latched");
    // wakeup has no effect in receive states
    a_wake_ignored_rx: assert property (@(posedge clk_sys) disable iff (rst)
        state_in_receive && !ev_channel_measure_done && !pending_q[EV_WAKE_MEASURE]
        |=> !pending_q[EV_WAKE_MEASURE])
        else $error("bit 4 set without measurement in receive");
    // transmit end counts as frame end
    a_tx_done_recorded: assert property (@(posedge clk_sys) disable iff (rst)
        ev_frame_tx_done && enable_q[EV_FRAME_DONE] |=> pending_q[EV_FRAME_DONE])
        else $error("transmit end not latched");
    // frame start lands on bit 2
    a_start_recorded: assert property (@(posedge clk_sys) disable iff (rst)
        ev_frame_start && enable_q[EV_FRAME_START] |=> pending_q[EV_FRAME_START])
        else $error("frame start not latched");
    // empty indicator drives the line active high
    a_empty_ind_line: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_one_q[CTL_EMPTY_IND_EN] && frame_buffer_reading
        |=> irq_line == $past(buffer_empty))
        else $error("empty indicator not on line");
    // serial status byte mirrors pending bits when selected
    a_serial_status: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_one_q[CTL_STATUS_SEL_HI:CTL_STATUS_SEL_LO] == STATUS_SEL_PENDING
        |=> serial_status_byte == $past(pending_q))
        else $error("serial status byte wrong");
    // serial status byte is empty otherwise
    a_serial_idle: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_one_q[CTL_STATUS_SEL_HI:CTL_STATUS_SEL_LO] != STATUS_SEL_PENDING
        |=> serial_status_byte == 8'h00)
        else $error("serial status byte not empty");
    // control writes land whole
    a_ctrl_write: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && hit(reg_addr, ADDR_CTRL_ONE) |=> ctrl_one_q == $past(reg_wdata))
        else $error("control write lost");
    // enable writes land whole
    a_enable_write: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && hit(reg_addr, ADDR_ENABLE) |=> enable_q == $past(reg_wdata))
        else $error("enable write lost");
    // status read returns the bits before the clear
    a_read_returns: assert property (@(posedge clk_sys) disable iff (rst)
        read_pending |=> reg_rdata == $past(pending_q))
        else $error("status read returned wrong bits");
    // polling mode records a masked wakeup
    a_poll_records: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_one_q[CTL_POLL_MODE] && ev_wakeup_done && !state_in_receive
        |=> pending_q[EV_WAKE_MEASURE])
        else $error("polling mode lost an event");
    // reception end drops the aux pin
    a_aux_frame_end: assert property (@(posedge clk_sys) disable iff (rst)
        ev_frame_rx_done && !ev_frame_start |=> !aux_output_two)
        else $error("aux output two not dropped");
    // amplifier stays on without unlock
    a_pa_off_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !ev_synth_unlock |=> !pa_off)
        else $error("amplifier switched off without unlock");
endmodule : radio_interrupt_logic

/* sim/host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// host side: register master that services the request line
module host_model (
    input wire logic clk_sys,
    input wire logic irq_line,
    output logic reg_wr,
    output logic reg_rd,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // bus idle at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
    end
    // one strobe per edge; released lines carry scrambled values
    task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : access
    // wait a bounded time for the line before reading the cause
    task automatic await(input logic lvl, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 8 && !seen; i++) begin
            @(posedge clk_sys);
            #1;
            seen = (irq_line === lvl);
        end
    endtask : await
endmodule : host_model

/* sim/radio_interrupt_logic_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// bench for the interrupt block
module radio_interrupt_logic_tb;
    import irq_logic_pkg::*;
    logic clk_sys, rst, reg_wr, reg_rd, irq_line, aux_output_two, pa_off, seen;
    logic frame_buffer_reading, buffer_empty, front_end_control_enable, tx_auto_checksum;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, serial_status_byte, lfsr;
    logic [9:0] ev;
    trx_state_e trx_state;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    int bit_of[10] = '{0, 1, 2, 3, 3, 4, 4, 5, 6, 7};
    radio_interrupt_logic u_radio_interrupt_logic (.clk_sys, .rst, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .trx_state, .ev_supply_low(ev[9]),
        .ev_buffer_violation(ev[8]), .ev_address_match(ev[7]),
        .ev_wakeup_done(ev[5]), .ev_channel_measure_done(ev[6]),
        .ev_frame_start(ev[2]), .ev_frame_rx_done(ev[3]), .ev_frame_tx_done(ev[4]),
        .ev_synth_unlock(ev[1]), .ev_synth_lock(ev[0]), .frame_buffer_reading,
        .buffer_empty, .irq_line, .aux_output_two, .pa_off, .serial_status_byte,
        .front_end_control_enable, .tx_auto_checksum);
    host_model host (.clk_sys, .irq_line, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    // ======================================================
    // helpers
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic pulse(input int i);
        cyc(1);
        ev[i] = 1'b1;
        cyc(1);
        ev[i] = 1'b0;
    endtask : pulse
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    // ======================================================
    // clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end
    // compare each read answer with the oldest note
    always @(posedge clk_sys) begin
        if (reg_rd === 1'b1) begin
            #2;
            check("reg_rdata", reg_rdata, exp_q.pop_front());
        end
    end
    // ======================================================
    // main sequence
    initial begin
        rst = 1'b1;
        ev = 10'h000;
        trx_state = ST_IDLE_CLOCK;
        frame_buffer_reading = 1'b0;
        buffer_empty = 1'b0;
        lfsr = 8'h43;
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        check("irq_line", {7'h00, irq_line}, 8'h00);
        check("serial_status", serial_status_byte, 8'h00);
        rd(ADDR_CTRL_ONE, CTRL_ONE_RESET);
        rd(ADDR_ENABLE, ENABLE_RESET);
        rd(ADDR_PENDING, PENDING_RESET);
        rd(ADDR_IDENT, 8'h5a);
        rd(6'h10, 8'h00);
        // random enable patterns gate the lock event
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            wr(ADDR_ENABLE, lfsr);
            rd(ADDR_ENABLE, lfsr);
            pulse(0);
            cyc(1);
            check("irq_line", {7'h00, irq_line}, {7'h00, lfsr[0]});
            rd(ADDR_PENDING, {7'h00, lfsr[0]});
        end
        // each source lands on its mapped sticky bit; both frame ends share bit 3, wakeup and measurement share bit 4
        wr(ADDR_ENABLE, 8'hff);
        for (int i = 0; i < 10; i++) begin
            trx_state = (i == 6) ? ST_RECEIVE_LISTEN : ST_IDLE_CLOCK;
            pulse(i);
            cyc(4);
            check("irq_line", {7'h00, irq_line}, 8'h01);
            host.await(1'b1, seen);
            check("irq_seen", {7'h00, seen}, 8'h01);
            rd(ADDR_PENDING, 8'h01 << bit_of[i]);
            cyc(1);
            check("irq_cleared", {7'h00, irq_line}, 8'h00);
        end
        // wakeup is ignored in receive states, measurement is taken
        trx_state = ST_BUSY_RECEIVE;
        pulse(5);
        rd(ADDR_PENDING, 8'h00);
        pulse(6);
        rd(ADDR_PENDING, 8'h10);
        trx_state = ST_IDLE_CLOCK;
        // lock and unlock cancel each other, reads race events
        pulse(0);
        pulse(1);
        check("pa_off_idle", {7'h00, pa_off}, 8'h00);
        rd(ADDR_PENDING, 8'h02);
        pulse(1);
        pulse(0);
        rd(ADDR_PENDING, 8'h01);
        pulse(7);
        fork
            rd(ADDR_PENDING, 8'h20);
            pulse(9);
        join
        rd(ADDR_PENDING, 8'h80);
        // unlock while sending switches the amplifier off
        for (int s = 0; s < 2; s++) begin
            trx_state = s ? ST_RETRYING_TRANSMIT : ST_BUSY_TRANSMIT;
            pulse(1);
            check("pa_off", {7'h00, pa_off}, 8'h01);
            rd(ADDR_PENDING, 8'h02);
        end
        trx_state = ST_IDLE_CLOCK;
        // polling mode records masked events without raising the line
        wr(ADDR_ENABLE, 8'h00);
        wr(ADDR_CTRL_ONE, 8'h02);
        rd(ADDR_PENDING, 8'h00);
        pulse(5);
        cyc(2);
        check("irq_poll", {7'h00, irq_line}, 8'h00);
        check("serial_off", serial_status_byte, 8'h00);
        rd(ADDR_PENDING, 8'h10);
        // active-low request line
        wr(ADDR_CTRL_ONE, 8'h01);
        wr(ADDR_ENABLE, 8'h04);
        cyc(1);
        check("irq_low_idle", {7'h00, irq_line}, 8'h01);
        pulse(2);
        cyc(1);
        check("irq_low_act", {7'h00, irq_line}, 8'h00);
        rd(ADDR_PENDING, 8'h04);
        // empty indicator takes the line, active high
        wr(ADDR_CTRL_ONE, 8'h11);
        frame_buffer_reading = 1'b1;
        buffer_empty = 1'b1;
        cyc(2);
        check("empty_ind", {7'h00, irq_line}, 8'h01);
        buffer_empty = 1'b0;
        cyc(2);
        check("empty_ind", {7'h00, irq_line}, 8'h00);
        frame_buffer_reading = 1'b0;
        // frame pin follows the frame with its event masked
        wr(ADDR_ENABLE, 8'h00);
        pulse(3);
        wr(ADDR_CTRL_ONE, 8'h40);
        check("aux_idle", {7'h00, aux_output_two}, 8'h00);
        pulse(2);
        cyc(3);
        check("aux_two", {7'h00, aux_output_two}, 8'h01);
        pulse(3);
        check("aux_two", {7'h00, aux_output_two}, 8'h00);
        rd(ADDR_PENDING, 8'h00);
        // other control fields and the serial status byte
        wr(ADDR_CTRL_ONE, 8'hac);
        rd(ADDR_CTRL_ONE, 8'hac);
        check("fields", {6'h00, front_end_control_enable, tx_auto_checksum}, 8'h03);
        wr(ADDR_ENABLE, 8'hff);
        pulse(8);
        cyc(2);
        check("serial_status", serial_status_byte, 8'h40);
        // a reset in mid-run clears enables and pending bits
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        check("irq_reset", {7'h00, irq_line}, 8'h00);
        check("serial_reset", serial_status_byte, 8'h00);
        rd(ADDR_ENABLE, ENABLE_RESET);
        rd(ADDR_PENDING, PENDING_RESET);
        cyc(1);
        results();
    end
endmodule : radio_interrupt_logic_tb
